//--- hw/rvp_device.sv
// Contract
// - Programmer holds reset through whole sequence
// - Strobes and mode port start high
// - Fetch strobe low after two cycles, held
// - Supply-level access pin, latch strobe high
// - Mode code held; 28h, 29h, 2Bh decoded
// - Address high on Port 1, low Port 3
// - Device drives selected byte on Port 2
// - Signature bytes at 30h, 31h, 60h, 61h
// - Key array is never readable here
// - Access pin back at supply before verify
// - Releasing strobes ends the sequence
// - Code byte XNOR key at address[6:0]
// - Lock level 2+ refuses code verify
module rvp_device (
  input wire logic sys_clk,
  input wire logic sys_rst,
  rvp_if.dev link,
  input wire logic load_en,
  input wire logic [1:0] load_area,
  input wire logic [15:0] load_addr,
  input wire logic [7:0] load_data,
  output logic in_verify
);
  // ==========================================================
  // Decode of mode and address to a source
  function automatic rvp_pkg::rvp_src_t src_of(
    input logic [7:0] mode,
    input logic [15:0] addr,
    input logic [2:0] lock
  );
    rvp_pkg::rvp_src_t r;
    r = rvp_pkg::SRC_NONE;
    if (mode == rvp_pkg::MODE_CODE) begin
      // Refused reads float to the pull-up level
      if (addr <= rvp_pkg::CODE_ADDR_MAX && !lock[rvp_pkg::LOCK_LEVEL2_BIT]
          && !lock[rvp_pkg::LOCK_LEVEL3_BIT]) begin
        r = rvp_pkg::SRC_CODE;
      end
    end else if (mode == rvp_pkg::MODE_CFG_SIG) begin
      if (addr == rvp_pkg::ADDR_CFG_LOW || addr == rvp_pkg::ADDR_CFG_HIGH ||
          addr == rvp_pkg::ADDR_SIG0 || addr == rvp_pkg::ADDR_SIG1 ||
          addr == rvp_pkg::ADDR_SIG2 || addr == rvp_pkg::ADDR_SIG3) begin
        r = rvp_pkg::SRC_CONST;
      end
    end else if (mode == rvp_pkg::MODE_LOCK) begin
      if (addr == rvp_pkg::ADDR_LOCK) begin
        r = rvp_pkg::SRC_CONST;
      end
    end
    // No mode code selects the key array
    return r;
  endfunction

  // ==========================================================
  // State
  typedef struct packed {
    rvp_pkg::rvp_dev_state_t st;
    logic [2:0] cnt;
    logic [7:0] cfg_low;
    logic [7:0] cfg_high;
    logic [2:0] lock;
    logic [rvp_pkg::KEY_DEPTH-1:0] key_set;
    rvp_pkg::rvp_src_t src;
    logic [7:0] const_byte;
    logic [7:0] p2;
    logic p2_oe_n;
    logic verify;
  } rvp_dev_s_t;

  rvp_dev_s_t s_reg;
  rvp_dev_s_t s_next;

  logic [7:0] code_mem [rvp_pkg::CODE_DEPTH];
  logic [7:0] key_mem [rvp_pkg::KEY_DEPTH];
  logic [7:0] code_rd_reg;
  logic [7:0] key_rd_reg;
  logic [6:0] key_idx;
  logic [7:0] key_byte;
  logic start_ok;

  assign key_idx = link.port3[6:0];
  // Unwritten key bytes read erased, so plain code passes through
  assign key_byte = s_reg.key_set[key_idx] ? key_rd_reg : rvp_pkg::ERASED_BYTE;

  // ==========================================================
  // Arrays; no reset, load port writes them
  always_ff @(posedge sys_clk) begin
    if (load_en && load_area == rvp_pkg::LOAD_CODE) begin
      code_mem[load_addr[14:0]] <= load_data;
    end
    if (load_en && load_area == rvp_pkg::LOAD_KEY) begin
      key_mem[load_addr[6:0]] <= load_data;
    end
    code_rd_reg <= code_mem[{link.port1[6:0], link.port3}];
    key_rd_reg <= key_mem[key_idx];
  end

  assign start_ok = link.rst && link.code_fetch_strobe_n && link.latch_or_program_pulse &&
                    link.port0 == rvp_pkg::MODE_IDLE;

  always_comb begin
    s_next = s_reg;
    // Key bits track which key bytes were written
    for (int i = 0; i < rvp_pkg::KEY_DEPTH; i++) begin
      if (load_en && load_area == rvp_pkg::LOAD_KEY && load_addr[6:0] == 7'(i)) begin
        s_next.key_set[i] = 1'b1;
      end
    end
    if (load_en && load_area == rvp_pkg::LOAD_CFG) begin
      if (load_addr == rvp_pkg::ADDR_CFG_LOW) begin
        s_next.cfg_low = load_data;
      end
      if (load_addr == rvp_pkg::ADDR_CFG_HIGH) begin
        s_next.cfg_high = load_data;
      end
    end
    if (load_en && load_area == rvp_pkg::LOAD_LOCK) begin
      s_next.lock = load_data[2:0];
    end
    case (s_reg.st)
      rvp_pkg::DST_IDLE: begin
        s_next.cnt = 3'h0;
        if (start_ok) begin
          s_next.cnt = 3'h1;
          s_next.st = rvp_pkg::DST_ARM;
        end
      end
      rvp_pkg::DST_ARM: begin
        if (!link.rst) begin
          s_next.st = rvp_pkg::DST_IDLE;
        end else if (!link.code_fetch_strobe_n) begin
          // An early strobe does not open verify mode
          if (s_reg.cnt >= rvp_pkg::DEV_SETUP_CYCLES) begin
            s_next.st = rvp_pkg::DST_VERIFY;
          end else begin
            s_next.st = rvp_pkg::DST_IDLE;
          end
        end else if (start_ok) begin
          if (s_reg.cnt != 3'h7) begin
            s_next.cnt = s_reg.cnt + 3'h1;
          end
        end else begin
          s_next.st = rvp_pkg::DST_IDLE;
        end
      end
      rvp_pkg::DST_VERIFY: begin
        if (!link.rst || link.code_fetch_strobe_n) begin
          s_next.st = rvp_pkg::DST_IDLE;
        end
      end
      default: begin
        s_next.st = rvp_pkg::DST_IDLE;
      end
    endcase
    // Stage one: decode, one cycle behind the pins, like the array read
    s_next.src = src_of(link.port0, {link.port1, link.port3}, s_reg.lock);
    s_next.const_byte = rvp_pkg::ERASED_BYTE;
    case ({link.port1, link.port3})
      rvp_pkg::ADDR_CFG_LOW: s_next.const_byte = s_reg.cfg_low;
      rvp_pkg::ADDR_CFG_HIGH: s_next.const_byte = s_reg.cfg_high;
      rvp_pkg::ADDR_SIG0: s_next.const_byte = rvp_pkg::SIG_VAL0;
      rvp_pkg::ADDR_SIG1: s_next.const_byte = rvp_pkg::SIG_VAL1;
      rvp_pkg::ADDR_SIG2: s_next.const_byte = rvp_pkg::SIG_VAL2;
      rvp_pkg::ADDR_SIG3: s_next.const_byte = rvp_pkg::SIG_VAL3;
      default: s_next.const_byte = rvp_pkg::ERASED_BYTE;
    endcase
    if (link.port0 == rvp_pkg::MODE_LOCK) begin
      s_next.const_byte = {5'h00, s_reg.lock};
    end
    // Stage two: drive Port 2 only in verify with supply-level access pin
    s_next.p2_oe_n = 1'b1;
    s_next.p2 = rvp_pkg::ERASED_BYTE;
    if (s_reg.st == rvp_pkg::DST_VERIFY && link.external_access_n &&
        link.latch_or_program_pulse && s_reg.src != rvp_pkg::SRC_NONE) begin
      s_next.p2_oe_n = 1'b0;
      if (s_reg.src == rvp_pkg::SRC_CODE) begin
        s_next.p2 = ~(code_rd_reg ^ key_byte);
      end else begin
        s_next.p2 = s_reg.const_byte;
      end
    end
    s_next.verify = (s_next.st == rvp_pkg::DST_VERIFY);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.st <= rvp_pkg::DST_IDLE;
      s_reg.cfg_low <= rvp_pkg::ERASED_BYTE;
      s_reg.cfg_high <= rvp_pkg::ERASED_BYTE;
      s_reg.lock <= rvp_pkg::LOCK_RESET;
      s_reg.src <= rvp_pkg::SRC_NONE;
      s_reg.const_byte <= rvp_pkg::ERASED_BYTE;
      s_reg.p2 <= rvp_pkg::ERASED_BYTE;
      s_reg.p2_oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs
  assign link.port2_out = s_reg.p2;
  assign link.port2_oe_n = s_reg.p2_oe_n;
  assign in_verify = s_reg.verify;
endmodule

//--- pkg/rvp_pkg.sv
package rvp_pkg;
  // ==========================================================
  // Verify mode codes and idle level on the mode port
  localparam logic [7:0] MODE_CODE = 8'h28;
  localparam logic [7:0] MODE_CFG_SIG = 8'h29;
  localparam logic [7:0] MODE_LOCK = 8'h2b;
  localparam logic [7:0] MODE_IDLE = 8'hff;
  // ==========================================================
  // Verify addresses
  localparam logic [15:0] CODE_ADDR_MAX = 16'h7fff;
  localparam logic [15:0] ADDR_CFG_LOW = 16'hfff8;
  localparam logic [15:0] ADDR_CFG_HIGH = 16'hfff9;
  localparam logic [15:0] ADDR_LOCK = 16'h0000;
  localparam logic [15:0] ADDR_SIG0 = 16'h0030;
  localparam logic [15:0] ADDR_SIG1 = 16'h0031;
  localparam logic [15:0] ADDR_SIG2 = 16'h0060;
  localparam logic [15:0] ADDR_SIG3 = 16'h0061;
  // ==========================================================
  // Signature contents, values arbitrary
  localparam logic [7:0] SIG_VAL0 = 8'ha1;
  localparam logic [7:0] SIG_VAL1 = 8'hb2;
  localparam logic [7:0] SIG_VAL2 = 8'hc3;
  localparam logic [7:0] SIG_VAL3 = 8'hd4;
  // ==========================================================
  // Array sizes, erased values and lock bits
  localparam int CODE_DEPTH = 32768;
  localparam int KEY_DEPTH = 128;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [2:0] LOCK_RESET = 3'h0;
  localparam int LOCK_LEVEL2_BIT = 1;
  localparam int LOCK_LEVEL3_BIT = 2;
  // ==========================================================
  // Device side load areas
  localparam logic [1:0] LOAD_CODE = 2'h0;
  localparam logic [1:0] LOAD_KEY = 2'h1;
  localparam logic [1:0] LOAD_CFG = 2'h2;
  localparam logic [1:0] LOAD_LOCK = 2'h3;
  // ==========================================================
  // Timing counts in sys_clk cycles
  localparam logic [2:0] DEV_SETUP_CYCLES = 3'h2;
  localparam logic [2:0] HOST_SETUP_CYCLES = 3'h3;
  localparam logic [2:0] HOST_RESP_WAIT = 3'h3;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {DST_IDLE, DST_ARM, DST_VERIFY} rvp_dev_state_t;
  typedef enum logic [1:0] {SRC_NONE, SRC_CODE, SRC_CONST} rvp_src_t;
  typedef enum logic [1:0] {HST_IDLE, HST_SETUP, HST_WAIT, HST_READY} rvp_host_state_t;
endpackage

//--- pkg/rvp_if.sv
interface rvp_if;
  logic rst;
  logic code_fetch_strobe_n;
  logic latch_or_program_pulse;
  logic external_access_n;
  logic [7:0] port0;
  logic [7:0] port1;
  logic [7:0] port3;
  logic [7:0] port2_out;
  logic port2_oe_n;
  logic [7:0] port2;
  // Weak pull-ups read as all ones when the device does not drive
  assign port2 = port2_oe_n ? 8'hff : port2_out;
  modport dev(
    input rst,
    input code_fetch_strobe_n,
    input latch_or_program_pulse,
    input external_access_n,
    input port0,
    input port1,
    input port3,
    output port2_out,
    output port2_oe_n
  );
  modport host(
    output rst,
    output code_fetch_strobe_n,
    output latch_or_program_pulse,
    output external_access_n,
    output port0,
    output port1,
    output port3,
    input port2
  );
endinterface

//--- hw/rvp_host.sv
module rvp_host (
  input wire logic sys_clk,
  input wire logic sys_rst,
  rvp_if.host link,
  input wire logic req_valid,
  input wire logic [7:0] req_mode,
  input wire logic [15:0] req_addr,
  input wire logic end_req,
  output logic req_ready,
  output logic resp_valid,
  output logic [7:0] resp_data,
  output logic in_sequence
);
  // ==========================================================
  // State
  typedef struct packed {
    rvp_pkg::rvp_host_state_t st;
    logic [2:0] cnt;
    logic rst;
    logic fetch_n;
    logic [7:0] p0;
    logic [7:0] p1;
    logic [7:0] p3;
    logic [7:0] mode;
    logic [15:0] addr;
    logic ready;
    logic rvalid;
    logic [7:0] rdata;
  } rvp_host_s_t;

  rvp_host_s_t s_reg;
  rvp_host_s_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    case (s_reg.st)
      rvp_pkg::HST_IDLE: begin
        if (req_valid) begin
          s_next.rst = 1'b1;
          s_next.fetch_n = 1'b1;
          s_next.p0 = rvp_pkg::MODE_IDLE;
          s_next.mode = req_mode;
          s_next.addr = req_addr;
          s_next.cnt = 3'h0;
          s_next.ready = 1'b0;
          s_next.st = rvp_pkg::HST_SETUP;
        end
      end
      rvp_pkg::HST_SETUP: begin
        s_next.cnt = s_reg.cnt + 3'h1;
        // Margin of one cycle over the device's minimum
        if (s_reg.cnt == rvp_pkg::HOST_SETUP_CYCLES - 3'h1) begin
          s_next.fetch_n = 1'b0;
          s_next.p0 = s_reg.mode;
          s_next.p1 = s_reg.addr[15:8];
          s_next.p3 = s_reg.addr[7:0];
          s_next.cnt = 3'h0;
          s_next.st = rvp_pkg::HST_WAIT;
        end
      end
      rvp_pkg::HST_WAIT: begin
        s_next.cnt = s_reg.cnt + 3'h1;
        if (s_reg.cnt == rvp_pkg::HOST_RESP_WAIT) begin
          s_next.rvalid = 1'b1;
          s_next.rdata = link.port2;
          s_next.ready = 1'b1;
          s_next.st = rvp_pkg::HST_READY;
        end
      end
      rvp_pkg::HST_READY: begin
        if (end_req) begin
          s_next.rst = 1'b0;
          s_next.fetch_n = 1'b1;
          s_next.p0 = rvp_pkg::MODE_IDLE;
          s_next.st = rvp_pkg::HST_IDLE;
        end else if (req_valid) begin
          s_next.p0 = req_mode;
          s_next.p1 = req_addr[15:8];
          s_next.p3 = req_addr[7:0];
          s_next.cnt = 3'h0;
          s_next.ready = 1'b0;
          s_next.st = rvp_pkg::HST_WAIT;
        end
      end
      default: begin
        s_next.st = rvp_pkg::HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.st <= rvp_pkg::HST_IDLE;
      s_reg.fetch_n <= 1'b1;
      s_reg.p0 <= rvp_pkg::MODE_IDLE;
      s_reg.p1 <= 8'hff;
      s_reg.p3 <= 8'hff;
      s_reg.ready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs
  // The programming voltage path is not modelled, so these stay fixed
  assign link.external_access_n = 1'b1;
  assign link.latch_or_program_pulse = 1'b1;
  assign link.rst = s_reg.rst;
  assign link.code_fetch_strobe_n = s_reg.fetch_n;
  assign link.port0 = s_reg.p0;
  assign link.port1 = s_reg.p1;
  assign link.port3 = s_reg.p3;
  assign req_ready = s_reg.ready;
  assign resp_valid = s_reg.rvalid;
  assign resp_data = s_reg.rdata;
  assign in_sequence = s_reg.rst;
endmodule

//--- testbench/rvp_properties.sv
module rvp_properties (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic rst,
  input wire logic code_fetch_strobe_n,
  input wire logic latch_or_program_pulse,
  input wire logic external_access_n,
  input wire logic [7:0] port0,
  input wire logic [7:0] port1,
  input wire logic [7:0] port3,
  input wire logic [7:0] port2_out,
  input wire logic port2_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Link rules, one clock domain
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  property p_hold_rst;
    !code_fetch_strobe_n |-> rst;
  endproperty
  a_hold_rst: assert property (p_hold_rst) else $error("strobe low outside reset");
  property p_start_high;
    $rose(rst) |-> code_fetch_strobe_n && latch_or_program_pulse && port0 == 8'hff;
  endproperty
  a_start_high: assert property (p_start_high) else $error("start not high");
  // Two sampled cycles of setup before the strobe drops
  property p_setup;
    $fell(code_fetch_strobe_n) |-> $past(rst, 2) && $past(code_fetch_strobe_n, 2);
  endproperty
  a_setup: assert property (p_setup) else $error("strobe dropped early");
  property p_supply;
    rst |-> external_access_n && latch_or_program_pulse;
  endproperty
  a_supply: assert property (p_supply) else $error("access pin or latch low");
  property p_release;
    $fell(rst) |-> code_fetch_strobe_n && port0 == 8'hff;
  endproperty
  a_release: assert property (p_release) else $error("controls not released");
  property p_no_key;
    !port2_oe_n |-> $past(port0, 2) inside {8'h28, 8'h29, 8'h2b};
  endproperty
  a_no_key: assert property (p_no_key) else $error("driven under unknown mode");
  property p_sig_addr;
    !port2_oe_n && $past(port0, 2) == 8'h29 |->
      $past({port1, port3}, 2) inside {16'hfff8, 16'hfff9, 16'h0030, 16'h0031, 16'h0060, 16'h0061};
  endproperty
  a_sig_addr: assert property (p_sig_addr) else $error("bad signature address");
  property p_sig_val;
    !port2_oe_n && $past(port0, 2) == 8'h29 && $past({port1, port3}, 2) == 16'h0030 |->
      port2_out == rvp_pkg::SIG_VAL0;
  endproperty
  a_sig_val: assert property (p_sig_val) else $error("bad signature byte");
  property p_lock_rd;
    !port2_oe_n && $past(port0, 2) == 8'h2b |->
      $past({port1, port3}, 2) == 16'h0000 && port2_out[7:3] == 5'h00;
  endproperty
  a_lock_rd: assert property (p_lock_rd) else $error("bad lock read");
  c_code: cover property (!port2_oe_n && $past(port0, 2) == 8'h28);
  c_sig: cover property (!port2_oe_n && $past(port0, 2) == 8'h29);
  c_end: cover property ($fell(rst));
endmodule

//--- testbench/rom_verify_port_bench.sv
module rom_verify_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, sys_rst, req_valid, end_req, req_ready, resp_valid, in_sequence;
  logic [7:0] req_mode, resp_data, load_data;
  logic [15:0] req_addr, load_addr;
  logic load_en, in_verify, in_verify_b;
  logic [1:0] load_area;
  int errors, total_checks, cyc;
  logic [15:0] sig_a [4] = '{16'h0030, 16'h0031, 16'h0060, 16'h0061};
  logic [7:0] sig_v [4] = '{rvp_pkg::SIG_VAL0, rvp_pkg::SIG_VAL1, rvp_pkg::SIG_VAL2,
    rvp_pkg::SIG_VAL3};
  logic [2:0] lk [3] = '{3'h1, 3'h2, 3'h4};
  logic [7:0] code_exp [3] = '{8'h5a, 8'hff, 8'hff};
  rvp_if link_a();
  // Second link: the bench plays a programmer that breaks the rules
  rvp_if link_b();
  rvp_host u_rvp_host(.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link_a),
    .req_valid(req_valid), .req_mode(req_mode), .req_addr(req_addr), .end_req(end_req),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_data(resp_data),
    .in_sequence(in_sequence));
  rvp_device u_rvp_device(.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link_a),
    .load_en(load_en), .load_area(load_area), .load_addr(load_addr), .load_data(load_data),
    .in_verify(in_verify));
  rvp_device u_rvp_device_b(.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link_b),
    .load_en(load_en), .load_area(load_area), .load_addr(load_addr), .load_data(load_data),
    .in_verify(in_verify_b));
  rvp_properties u_rvp_properties(.sys_clk(sys_clk), .sys_rst(sys_rst), .rst(link_a.rst),
    .code_fetch_strobe_n(link_a.code_fetch_strobe_n),
    .latch_or_program_pulse(link_a.latch_or_program_pulse),
    .external_access_n(link_a.external_access_n), .port0(link_a.port0),
    .port1(link_a.port1), .port3(link_a.port3), .port2_out(link_a.port2_out),
    .port2_oe_n(link_a.port2_oe_n));
  // ==========================================================
  // Tasks
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic load(input logic [1:0] area, input logic [15:0] addr, input logic [7:0] data);
    @(negedge sys_clk);
    load_en = 1'b1;
    load_area = area;
    load_addr = addr;
    load_data = data;
    @(negedge sys_clk);
    load_en = 1'b0;
  endtask
  task automatic vchk(input logic [7:0] mode, input logic [15:0] addr, input logic [7:0] exp);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    // A host that never frees up must not let a stale answer pass
    if (n >= 50) begin
      errors++;
    end
    req_valid = 1'b1;
    req_mode = mode;
    req_addr = addr;
    @(negedge sys_clk);
    req_valid = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 50) begin
      errors++;
    end
    check({8'h00, resp_data}, {8'h00, exp});
  endtask
  // Strobe drops after hi setup cycles, with signature 0 asked for in the same step
  task automatic arm_b(input int hi);
    @(negedge sys_clk);
    link_b.rst = 1'b0;
    link_b.code_fetch_strobe_n = 1'b1;
    link_b.port0 = 8'hff;
    @(negedge sys_clk);
    link_b.rst = 1'b1;
    repeat (hi) @(negedge sys_clk);
    link_b.code_fetch_strobe_n = 1'b0;
    link_b.port0 = rvp_pkg::MODE_CFG_SIG;
    {link_b.port1, link_b.port3} = rvp_pkg::ADDR_SIG0;
    repeat (4) @(negedge sys_clk);
  endtask
  // ==========================================================
  // Clock, timeout, sequence
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      print_verdict;
    end
  end
  initial begin
    {errors, total_checks, cyc} = '0;
    {req_valid, end_req, load_en, load_area, load_addr, load_data} = '0;
    req_mode = 8'hff;
    req_addr = 16'h0000;
    {link_b.rst, link_b.code_fetch_strobe_n} = 2'b01;
    {link_b.latch_or_program_pulse, link_b.external_access_n} = 2'b11;
    {link_b.port0, link_b.port1, link_b.port3} = 24'hffffff;
    sys_rst = 1'b1;
    repeat (4) @(negedge sys_clk);
    sys_rst = 1'b0;
    load(rvp_pkg::LOAD_CODE, 16'h0005, 8'h3c);
    load(rvp_pkg::LOAD_CODE, 16'h0085, 8'h3c);
    load(rvp_pkg::LOAD_KEY, 16'h0005, 8'h0f);
    load(rvp_pkg::LOAD_CODE, 16'h0006, 8'h5a);
    load(rvp_pkg::LOAD_CFG, rvp_pkg::ADDR_CFG_LOW, 8'h12);
    for (int i = 0; i < 4; i++) begin
      vchk(rvp_pkg::MODE_CFG_SIG, sig_a[i], sig_v[i]);
    end
    check({15'h0000, in_verify}, 16'h0001);
    vchk(rvp_pkg::MODE_CODE, 16'h0005, 8'hcc);
    vchk(rvp_pkg::MODE_CODE, 16'h0085, 8'hcc);
    vchk(rvp_pkg::MODE_CODE, 16'h0006, 8'h5a);
    vchk(rvp_pkg::MODE_CODE, 16'h8000, 8'hff);
    vchk(8'h6c, 16'h0005, 8'hff);
    vchk(8'h2a, 16'h0005, 8'hff);
    vchk(rvp_pkg::MODE_CFG_SIG, rvp_pkg::ADDR_CFG_LOW, 8'h12);
    vchk(rvp_pkg::MODE_CFG_SIG, 16'h0032, 8'hff);
    vchk(rvp_pkg::MODE_LOCK, rvp_pkg::ADDR_LOCK, 8'h00);
    vchk(rvp_pkg::MODE_LOCK, 16'h0001, 8'hff);
    for (int i = 0; i < 3; i++) begin
      load(rvp_pkg::LOAD_LOCK, 16'h0000, {5'h00, lk[i]});
      vchk(rvp_pkg::MODE_CODE, 16'h0006, code_exp[i]);
      vchk(rvp_pkg::MODE_CFG_SIG, rvp_pkg::ADDR_CFG_LOW, 8'h12);
      vchk(rvp_pkg::MODE_LOCK, rvp_pkg::ADDR_LOCK, {5'h00, lk[i]});
    end
    @(negedge sys_clk);
    end_req = 1'b1;
    @(negedge sys_clk);
    end_req = 1'b0;
    repeat (2) @(negedge sys_clk);
    check({14'h0000, in_sequence, in_verify}, 16'h0000);
    vchk(rvp_pkg::MODE_LOCK, rvp_pkg::ADDR_LOCK, 8'h04);
    arm_b(1);
    check({8'h00, link_b.port2}, 16'h00ff);
    check({15'h0000, in_verify_b}, 16'h0000);
    arm_b(2);
    check({8'h00, link_b.port2}, {8'h00, rvp_pkg::SIG_VAL0});
    check({15'h0000, in_verify_b}, 16'h0001);
    link_b.latch_or_program_pulse = 1'b0;
    repeat (3) @(negedge sys_clk);
    check({8'h00, link_b.port2}, 16'h00ff);
    // Latch back high, else the device never arms and the next check fails
    link_b.latch_or_program_pulse = 1'b1;
    arm_b(2);
    check({8'h00, link_b.port2}, {8'h00, rvp_pkg::SIG_VAL0});
    link_b.external_access_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    check({8'h00, link_b.port2}, 16'h00ff);
    print_verdict;
  end
endmodule
